/* rtl/eec_defines.svh */
`ifndef EEC_DEFINES_SVH
`define EEC_DEFINES_SVH

// Line counts and pin mapping
`define EEC_LINES       18
`define EEC_EXT_LINES   16
`define EEC_PINS        80
`define EEC_PORTS       5
`define EEC_SEL_W       3
`define EEC_PIN_IDX_W   7
`define EEC_LINE_SVD    16
`define EEC_LINE_ALARM  17

// Register bus geometry
`define EEC_ADDR_W      5
`define EEC_DATA_W      32
`define EEC_BE_W        4
`define EEC_BYTE_W      8
`define EEC_SEL_REG_W   24

// Register byte offsets
`define EEC_OFS_INT_EN  5'h00
`define EEC_OFS_EVT_EN  5'h04
`define EEC_OFS_RISE    5'h08
`define EEC_OFS_FALL    5'h0C
`define EEC_OFS_PEND    5'h10
`define EEC_OFS_CLR     5'h14
`define EEC_OFS_SEL_LO  5'h18
`define EEC_OFS_SEL_HI  5'h1C

// Reset values
`define EEC_RST_LINES   18'h00000
`define EEC_RST_SEL     24'h000000
`define EEC_RST_DATA    32'h00000000

`endif

/* rtl/eec_pkg.sv */
package eec_pkg;
  // One bit for each edge-detection line
  typedef logic [17:0] line_vec_t;

  // Avalon-MM request carried as one bundle
  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avmm_req_t;
endpackage

/* rtl/line_edge_capture.sv */
`timescale 1ns/1ps
module line_edge_capture (
  input  wire logic ref_clk,   // System clock
  input  wire logic rst_n,     // Async reset, active low
  input  wire logic src,       // Asynchronous line source
  output logic      rise_evt,  // One-cycle pulse per rising edge
  output logic      fall_evt,  // One-cycle pulse per falling edge
  output logic      rise_raw,  // Unseen rising edge, no clock needed
  output logic      fall_raw   // Unseen falling edge, no clock needed
);
  logic rise_tog;
  logic fall_tog;
  logic rise_s1;
  logic rise_s2;
  logic fall_s1;
  logic fall_s2;
  logic rise_seen;
  logic fall_seen;

  // Source edge itself clocks a toggle, so pulses shorter than ref_clk survive
  always_ff @(posedge src or negedge rst_n) begin // see R05
    if (!rst_n) rise_tog <= 1'b0;
    else        rise_tog <= ~rise_tog;
  end

  always_ff @(negedge src or negedge rst_n) begin // see R05
    if (!rst_n) fall_tog <= 1'b0;
    else        fall_tog <= ~fall_tog;
  end

  // Toggle crossing into ref_clk; two edges of one kind within one cycle cancel and neither is seen
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_s1   <= 1'b0;
      rise_s2   <= 1'b0;
      fall_s1   <= 1'b0;
      fall_s2   <= 1'b0;
      rise_seen <= 1'b0;
      fall_seen <= 1'b0;
    end else begin
      rise_s1   <= rise_tog;
      rise_s2   <= rise_s1;
      fall_s1   <= fall_tog;
      fall_s2   <= fall_s1;
      rise_seen <= rise_s2;
      fall_seen <= fall_s2;
    end
  end

  // Clocked events from the settled copies
  assign rise_evt = rise_s2 ^ rise_seen;
  assign fall_evt = fall_s2 ^ fall_seen;

  // Raw mismatch stays high while the clock is stopped
  assign rise_raw = rise_tog ^ rise_seen; // see R08
  assign fall_raw = fall_tog ^ fall_seen; // see R08
endmodule

/* rtl/external_edge_event_controller.sv */
// Functional notes
// R01: Eighteen lines, each interrupt or event capable
// R02: Per-line choice of rising, falling or both
// R03: Per-line mask blocks that line's request only
// R04: Detected edge sets readable pending flag
// R05: Pulses shorter than bus clock still caught
// R06: Any of 80 pins onto sixteen lines
// R07: Sources: pin lines, voltage detector, alarm
// R08: Enabled edge wakes device with clocks stopped
// R09: Writing one clears pending, zero keeps it
`timescale 1ns/1ps
`include "eec_defines.svh"
module external_edge_event_controller (
  input  wire logic                   ref_clk,         // 100 MHz clock
  input  wire logic                   rst_n,           // Async reset, active low
  input  wire eec_pkg::avmm_req_t     avm_req,         // Avalon-MM request bundle
  output logic [`EEC_DATA_W-1:0]      avm_readdata,    // Registered read data
  output logic                        avm_waitrequest, // Stall, one wait cycle
  input  wire logic [`EEC_PINS-1:0]   gpio_in,         // General-purpose pins
  input  wire logic                   svd_out,         // Supply voltage detector output
  input  wire logic                   calendar_alarm,  // Calendar alarm signal
  output logic                        irq,             // Level interrupt request
  output logic                        wake_req,        // Async wake from Stop
  output eec_pkg::line_vec_t          event_line,      // Per-line event pulses
  output logic                        event_req        // Any event pulse
);
  import eec_pkg::*;

  line_vec_t                        int_enable;
  line_vec_t                        event_enable;
  line_vec_t                        rise_select;
  line_vec_t                        fall_select;
  line_vec_t                        pending;
  logic [`EEC_SEL_REG_W-1:0]        port_sel_lo;
  logic [`EEC_SEL_REG_W-1:0]        port_sel_hi;
  logic                             ack;
  line_vec_t                        line_src;
  line_vec_t                        rise_evt;
  line_vec_t                        fall_evt;
  line_vec_t                        rise_raw;
  line_vec_t                        fall_raw;
  line_vec_t                        trig;
  line_vec_t                        next_pending;
  line_vec_t                        clr_bits;
  logic [2*`EEC_SEL_REG_W-1:0]      sel_all;
  logic [`EEC_SEL_W-1:0]            port_of [`EEC_EXT_LINES];
  logic [`EEC_DATA_W-1:0]           be_bits;
  logic [`EEC_DATA_W-1:0]           rd_mux;
  logic                             req;
  logic                             wr;
  logic                             hit_int;
  logic                             hit_evt;
  logic                             hit_rise;
  logic                             hit_fall;
  logic                             hit_pend;
  logic                             hit_clr;
  logic                             hit_lo;
  logic                             hit_hi;

  // Byte enables widened to a bit mask
  function automatic logic [`EEC_DATA_W-1:0] be_mask(input logic [`EEC_BE_W-1:0] be);
    logic [`EEC_DATA_W-1:0] m;
    m = `EEC_RST_DATA;
    for (int b = 0; b < `EEC_BE_W; b++) begin
      m[b*`EEC_BYTE_W +: `EEC_BYTE_W] = {`EEC_BYTE_W{be[b]}};
    end
    return m;
  endfunction

  // Byte-lane merge of a write into an old value
  function automatic logic [`EEC_DATA_W-1:0] merge(input logic [`EEC_DATA_W-1:0] old,
                                                   input logic [`EEC_DATA_W-1:0] wd,
                                                   input logic [`EEC_DATA_W-1:0] m);
    return (old & ~m) | (wd & m);
  endfunction

  // Pin number for a line; an unused port code falls back to port 0
  function automatic logic [`EEC_PIN_IDX_W-1:0] pin_index(input logic [`EEC_SEL_W-1:0] port,
                                                          input int line);
    logic [`EEC_PIN_IDX_W-1:0] p;
    p = (port < `EEC_SEL_W'(`EEC_PORTS)) ? `EEC_PIN_IDX_W'(port) : `EEC_PIN_IDX_W'(0);
    return `EEC_PIN_IDX_W'(p * `EEC_PIN_IDX_W'(`EEC_EXT_LINES) + `EEC_PIN_IDX_W'(line));
  endfunction

  // Address decode and handshake
  assign req             = avm_req.read | avm_req.write;
  assign avm_waitrequest = req & ~ack;
  assign wr              = ack & avm_req.write;
  assign hit_int         = avm_req.address == `EEC_OFS_INT_EN;
  assign hit_evt         = avm_req.address == `EEC_OFS_EVT_EN;
  assign hit_rise        = avm_req.address == `EEC_OFS_RISE;
  assign hit_fall        = avm_req.address == `EEC_OFS_FALL;
  assign hit_pend        = avm_req.address == `EEC_OFS_PEND;
  assign hit_clr         = avm_req.address == `EEC_OFS_CLR;
  assign hit_lo          = avm_req.address == `EEC_OFS_SEL_LO;
  assign hit_hi          = avm_req.address == `EEC_OFS_SEL_HI;
  assign be_bits         = be_mask(avm_req.byteenable);

  // Read selection; clear register and unmapped words read zero
  assign rd_mux = hit_int  ? `EEC_DATA_W'(int_enable)   :
                  hit_evt  ? `EEC_DATA_W'(event_enable) :
                  hit_rise ? `EEC_DATA_W'(rise_select)  :
                  hit_fall ? `EEC_DATA_W'(fall_select)  :
                  hit_pend ? `EEC_DATA_W'(pending)      :
                  hit_lo   ? `EEC_DATA_W'(port_sel_lo)  :
                  hit_hi   ? `EEC_DATA_W'(port_sel_hi)  : `EEC_RST_DATA;

  // Pin routing for the external lines
  assign sel_all = {port_sel_hi, port_sel_lo};
  genvar g;
  generate
    for (g = 0; g < `EEC_EXT_LINES; g++) begin : g_mux
      assign port_of[g]  = sel_all[g*`EEC_SEL_W +: `EEC_SEL_W];
      assign line_src[g] = gpio_in[pin_index(port_of[g], g)]; // see R06, R07
    end
  endgenerate
  // Internal sources on the upper lines
  assign line_src[`EEC_LINE_SVD]   = svd_out;        // see R07
  assign line_src[`EEC_LINE_ALARM] = calendar_alarm; // see R07

  // A mux change may itself look like an edge; reprogram with the line disabled
  generate
    for (g = 0; g < `EEC_LINES; g++) begin : g_line
      line_edge_capture u_cap (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .src      (line_src[g]),
        .rise_evt (rise_evt[g]),
        .fall_evt (fall_evt[g]),
        .rise_raw (rise_raw[g]),
        .fall_raw (fall_raw[g])
      ); // see R01, R05
    end
  endgenerate

  // Trigger selection per line, both edges when both bits set
  assign trig = (rise_evt & rise_select) | (fall_evt & fall_select); // see R02

  // Write-one clear; a new edge in the same cycle wins over the clear
  assign clr_bits     = (wr && (hit_pend || hit_clr)) ?
                        line_vec_t'(avm_req.writedata & be_bits) : `EEC_RST_LINES; // see R09
  assign next_pending = (pending & ~clr_bits) | trig; // see R04

  // Requests toward the processor, gated per line
  assign irq      = |(pending & int_enable); // see R03
  assign wake_req = |(((rise_raw & rise_select) | (fall_raw & fall_select)) &
                      (int_enable | event_enable)); // see R08

  // Bus handshake and read capture
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack          <= 1'b0;
      avm_readdata <= `EEC_RST_DATA;
    end else begin
      ack <= req & ~ack;
      if (avm_req.read && !ack) avm_readdata <= rd_mux;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_enable   <= `EEC_RST_LINES;
      event_enable <= `EEC_RST_LINES;
      rise_select  <= `EEC_RST_LINES;
      fall_select  <= `EEC_RST_LINES;
      port_sel_lo  <= `EEC_RST_SEL;
      port_sel_hi  <= `EEC_RST_SEL;
    end else if (wr) begin
      if (hit_int)  int_enable   <= line_vec_t'(merge(`EEC_DATA_W'(int_enable),
                                                      avm_req.writedata, be_bits));
      if (hit_evt)  event_enable <= line_vec_t'(merge(`EEC_DATA_W'(event_enable),
                                                      avm_req.writedata, be_bits));
      if (hit_rise) rise_select  <= line_vec_t'(merge(`EEC_DATA_W'(rise_select),
                                                      avm_req.writedata, be_bits));
      if (hit_fall) fall_select  <= line_vec_t'(merge(`EEC_DATA_W'(fall_select),
                                                      avm_req.writedata, be_bits));
      if (hit_lo)   port_sel_lo  <= `EEC_SEL_REG_W'(merge(`EEC_DATA_W'(port_sel_lo),
                                                          avm_req.writedata, be_bits));
      if (hit_hi)   port_sel_hi  <= `EEC_SEL_REG_W'(merge(`EEC_DATA_W'(port_sel_hi),
                                                          avm_req.writedata, be_bits));
    end
  end

  // Pending flags and event pulses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending    <= `EEC_RST_LINES;
      event_line <= `EEC_RST_LINES;
      event_req  <= 1'b0;
    end else begin
      pending    <= next_pending;           // see R04
      event_line <= trig & event_enable;    // see R01, R03
      event_req  <= |(trig & event_enable); // see R01
    end
  end

  // Checks
  sequence s_req_first;
    req && !ack;
  endsequence

  // Line 3 carries most of the edge traffic, so this antecedent is reached
  sequence s_rise3;
    rise_evt[3] && rise_select[3];
  endsequence

  property p_bus_one_wait;
    @(posedge ref_clk) disable iff (!rst_n)
      s_req_first |-> avm_waitrequest ##1 !avm_waitrequest;
  endproperty
  a_bus_one_wait: assert property (p_bus_one_wait) else $error("bus wait not one cycle");

  property p_event_follows;
    @(posedge ref_clk) disable iff (!rst_n)
      (|(trig & event_enable)) |=> event_req && (event_line == $past(trig & event_enable));
  endproperty
  a_event_follows: assert property (p_event_follows) else $error("event pulse lost"); // see R01

  property p_no_select_no_trig;
    @(posedge ref_clk) disable iff (!rst_n)
      (rise_select == `EEC_RST_LINES && fall_select == `EEC_RST_LINES) |-> trig == `EEC_RST_LINES;
  endproperty
  a_no_select_no_trig: assert property (p_no_select_no_trig) // see R02
    else $error("unselected edge");

  property p_masked_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
      ((pending & int_enable) == `EEC_RST_LINES) |-> !irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) // see R03
    else $error("masked line raised irq");

  property p_pending_set;
    @(posedge ref_clk) disable iff (!rst_n)
      (|trig) |=> ((pending & $past(trig)) == $past(trig));
  endproperty
  a_pending_set: assert property (p_pending_set) else $error("pending not set"); // see R04

  property p_rise_to_pending;
    @(posedge ref_clk) disable iff (!rst_n)
      s_rise3 |-> trig[3] ##1 pending[3];
  endproperty
  a_rise_to_pending: assert property (p_rise_to_pending) // see R05
    else $error("edge not captured");

  property p_line0_route;
    @(posedge ref_clk) disable iff (!rst_n)
      (port_sel_lo[2:0] < 3'h5) |-> line_src[0] == gpio_in[{port_sel_lo[2:0], 4'h0}];
  endproperty
  a_line0_route: assert property (p_line0_route) else $error("line 0 misrouted"); // see R06

  property p_internal_src;
    @(posedge ref_clk) disable iff (!rst_n)
      line_src[`EEC_LINE_SVD] == svd_out && line_src[`EEC_LINE_ALARM] == calendar_alarm;
  endproperty
  a_internal_src: assert property (p_internal_src) // see R07
    else $error("internal source misrouted");

  property p_wake_on_trig;
    @(posedge ref_clk) disable iff (!rst_n)
      (|(trig & (int_enable | event_enable))) |-> wake_req;
  endproperty
  a_wake_on_trig: assert property (p_wake_on_trig) // see R08
    else $error("no wake on enabled edge");
endmodule

/* testbench/pin_source_model.sv */
`timescale 1ns/1ps
module pin_source_model (
  output logic [79:0] gpio_in,        // General-purpose pins
  output logic        svd_out,        // Voltage detector output
  output logic        calendar_alarm  // Calendar alarm
);
  logic [81:0] pins;  // 80 = detector, 81 = alarm

  // Push-pull drivers: levels hold between changes
  assign gpio_in        = pins[79:0];
  assign svd_out        = pins[80];
  assign calendar_alarm = pins[81];
  initial pins = '0;

  // One edge on a pin
  task automatic toggle(input int idx);
    pins[idx] <= ~pins[idx];
  endtask

  // Glitch narrower than a clock period, so only async capture sees it
  task automatic pulse(input int idx, input int width_ns);
    pins[idx] <= ~pins[idx];
    #(width_ns);
    pins[idx] <= ~pins[idx];
  endtask
endmodule

/* testbench/external_edge_event_controller_tb.sv */
`timescale 1ns/1ps
`include "eec_defines.svh"
module external_edge_event_controller_tb;
  import eec_pkg::*;
  logic        ref_clk;
  logic        rst_n;
  logic        clk_run;
  avmm_req_t   req;
  logic [31:0] rdata;
  logic        wreq;
  logic [79:0] gpio;
  logic        svd;
  logic        alarm;
  logic        irq;
  logic        wake;
  line_vec_t   ev_line;
  logic        ev_req;
  logic [31:0] exp_q[$];
  logic [31:0] val;
  int          fail_count;
  int          checks_done;
  int          seed;
  int          ev_cnt;
  int          any_cnt;
  int          port;
  int          line;

  // Clock can be halted to mimic Stop mode
  always #5 ref_clk = clk_run ? ~ref_clk : ref_clk;

  external_edge_event_controller i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .avm_req(req), .avm_readdata(rdata),
    .avm_waitrequest(wreq), .gpio_in(gpio), .svd_out(svd), .calendar_alarm(alarm),
    .irq(irq), .wake_req(wake), .event_line(ev_line), .event_req(ev_req));

  pin_source_model i_pins (.gpio_in(gpio), .svd_out(svd), .calendar_alarm(alarm));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Read results are judged where they appear, oldest note first
  always @(posedge ref_clk) begin
    if (req.read && wreq === 1'b0 && exp_q.size() > 0) begin
      check(rdata, exp_q.pop_front());
    end
  end

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus_xfer(input logic [4:0] a, input logic rd, input logic [31:0] d,
                          input logic [3:0] be);
    @(posedge ref_clk);
    req <= '{address: a, read: rd, write: !rd, writedata: d, byteenable: be};
    do @(posedge ref_clk); while (wreq !== 1'b0);
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    bus_xfer(a, 1'b0, d, be);
  endtask

  task automatic bus_rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus_xfer(a, 1'b1, 32'h00000000, 4'hF);
  endtask

  // Let the edge pass the synchroniser, read pending, then clear all
  task automatic pend_check(input logic [31:0] e);
    repeat (6) @(posedge ref_clk);
    bus_rd(`EEC_OFS_PEND, e);
    bus_wr(`EEC_OFS_CLR, 32'hFFFFFFFF, 4'hF);
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end

  initial begin
    ref_clk = 1'b0;
    clk_run = 1'b1;
    rst_n = 1'b0;
    req = '0;
    fail_count = 0;
    checks_done = 0;
    seed = 32'h4fcfec9f;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // Reset values, then random readback with unused bits reading zero
    for (int a = 0; a < 8; a++) bus_rd(5'(a * 4), 32'h00000000);
    for (int a = 0; a < 8; a++) begin
      if (a == 4 || a == 5) continue;
      val = $random(seed);
      bus_wr(5'(a * 4), val, 4'hF);
      bus_rd(5'(a * 4), val & ((a >= 6) ? 32'h00FFFFFF : 32'h0003FFFF));
      bus_wr(5'(a * 4), 32'h00000000, 4'hF);
    end
    bus_wr(`EEC_OFS_INT_EN, 32'hFFFFFFFF, 4'h2);
    bus_rd(`EEC_OFS_INT_EN, 32'h0000FF00);
    bus_wr(`EEC_OFS_INT_EN, 32'h00000000, 4'hF);
    // Rising only, falling only, both, on line 3
    for (int m = 0; m < 3; m++) begin
      bus_wr(`EEC_OFS_RISE, (m != 1) ? 32'h8 : 32'h0, 4'hF);
      bus_wr(`EEC_OFS_FALL, (m != 0) ? 32'h8 : 32'h0, 4'hF);
      i_pins.toggle(3);
      pend_check((m != 1) ? 32'h8 : 32'h0);
      i_pins.toggle(3);
      pend_check((m != 0) ? 32'h8 : 32'h0);
    end
    // Mask gates irq only; zero writes keep pending, one clears it
    bus_wr(`EEC_OFS_FALL, 32'h0, 4'hF);
    bus_wr(`EEC_OFS_INT_EN, 32'h8, 4'hF);
    i_pins.toggle(3);
    repeat (6) @(posedge ref_clk);
    check(irq, 1'b1);
    bus_wr(`EEC_OFS_INT_EN, 32'h4, 4'hF);
    repeat (2) @(posedge ref_clk);
    check(irq, 1'b0);
    bus_wr(`EEC_OFS_PEND, 32'h0, 4'hF);
    bus_rd(`EEC_OFS_PEND, 32'h8);
    bus_wr(`EEC_OFS_PEND, 32'h8, 4'hF);
    bus_rd(`EEC_OFS_PEND, 32'h0);
    i_pins.toggle(3);
    pend_check(32'h0);
    i_pins.pulse(3, 2);
    pend_check(32'h8);
    // Wake with the clock halted low
    bus_wr(`EEC_OFS_INT_EN, 32'h8, 4'hF);
    @(negedge ref_clk);
    clk_run = 1'b0;
    #20;
    i_pins.pulse(3, 3);
    #20;
    check(wake, 1'b1);
    clk_run = 1'b1;
    pend_check(32'h8);
    check(wake, 1'b0);
    bus_wr(`EEC_OFS_INT_EN, 32'h0, 4'hF);
    bus_wr(`EEC_OFS_RISE, 32'h0, 4'hF);
    // Random pin routed onto a random external line
    for (int k = 0; k < 4; k++) begin
      port = {$random(seed)} % 5;
      line = {$random(seed)} % 16;
      val = 32'(port) << (3 * (line % 8));
      bus_wr((line < 8) ? `EEC_OFS_SEL_LO : `EEC_OFS_SEL_HI, val, 4'hF);
      bus_wr(`EEC_OFS_RISE, 32'h1 << line, 4'hF);
      i_pins.toggle(port * 16 + line);
      pend_check(32'h1 << line);
      bus_wr(`EEC_OFS_RISE, 32'h0, 4'hF);
      i_pins.toggle(port * 16 + line);
      pend_check(32'h0);
      bus_wr((line < 8) ? `EEC_OFS_SEL_LO : `EEC_OFS_SEL_HI, 32'h0, 4'hF);
    end
    // Internal sources raise one event pulse each, irq stays masked
    bus_wr(`EEC_OFS_EVT_EN, 32'h30000, 4'hF);
    bus_wr(`EEC_OFS_RISE, 32'h30000, 4'hF);
    for (int s = 80; s < 82; s++) begin
      ev_cnt = 0;
      any_cnt = 0;
      i_pins.toggle(s);
      repeat (8) begin
        @(posedge ref_clk);
        ev_cnt += int'(ev_line[s - 64] === 1'b1);
        any_cnt += int'(ev_req === 1'b1);
      end
      check(32'(ev_cnt), 32'h1);
      check(32'(any_cnt), 32'h1);
      check(irq, 1'b0);
      pend_check(32'h1 << (s - 64));
    end
    complete_run();
  end
endmodule
